// ===== core/pin_select.sv
/*
  One shared active-low pin: indicator or general output.
  Assumes the indicator input is already active low.
*/
`default_nettype none
module pin_select
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic select,
  input wire logic level,
  input wire logic indicator_n,
  output logic pin_n
);
  // ----------------------------------------------------------------
  // output mux
  // ----------------------------------------------------------------
  logic pin_d;
  // level bit set drives the pin low
  always_comb
  begin
    pin_d = select ? ~level : indicator_n;
  end
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      pin_n <= 1'b1;
    else if (clk_en)
      pin_n <= pin_d;
  end
endmodule // pin_select
`default_nettype wire

// ===== core/power_mode_ctrl.sv
/*
  Power mode decision: software suspend, sleep pin, standby select.
  Assumes sleep_pin is synchronous to clock.
*/
`default_nettype none
module power_mode_ctrl
  import self_control_pkg::*;
(
  input wire logic suspend_set,
  input wire logic sleep_enable,
  input wire logic standby_select,
  input wire logic sleep_pin,
  output power_state_t power_state
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // software suspend dominates the pin; disabled pin is never looked at
  always_comb
  begin
    if (suspend_set)
      power_state = PWR_SW_SUSPEND;
    else if (sleep_enable && !sleep_pin)
      power_state = standby_select ? PWR_HW_STANDBY : PWR_HW_SUSPEND;
    else
      power_state = PWR_ACTIVE;
  end
endmodule // power_mode_ctrl
`default_nettype wire

// ===== core/self_control_pkg.sv
/*
  Constants for the self-control block: register map, field positions,
  reset value and power-state encoding.
  Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
*/
`default_nettype none
package self_control_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SELF_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] IO_WRITE_ADDR = 8'h04;
  localparam logic [7:0] POWER_STATUS_ADDR = 8'h08;
  localparam logic [15:0] SELF_CONTROL_RESET = 16'h0015;
  localparam logic [5:0] SELF_CONTROL_ID = 6'h15;
  localparam logic [15:0] WRITABLE_MASK = 16'hF7C0;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RESET_BIT = 6;
  localparam int SUSPEND_BIT = 8;
  localparam int SLEEP_EN_BIT = 9;
  localparam int STANDBY_BIT = 10;
  localparam int OUT0_SEL_BIT = 12;
  localparam int OUT1_SEL_BIT = 13;
  localparam int OUT0_LVL_BIT = 14;
  localparam int OUT1_LVL_BIT = 15;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_SW_SUSPEND,
    PWR_HW_STANDBY,
    PWR_HW_SUSPEND
  } power_state_t;
endpackage
`default_nettype wire

// ===== core/self_control_power_led.sv
/*
  Self-control register with AXI4-Lite access, chip reset, power
  modes and shared LED pins.
  Assumes one write and one read at a time; inputs synchronous.
*/
`default_nettype none
// Functional notes
// - reset bit pulses chip reset, self-clears
// - suspend partially resets, keeps base and register
// - no transmit or receive while suspended
// - in-range io write wakes from suspend
// - enabled low sleep enters hardware low power
// - disabled sleep pin level is ignored
// - output0 select: link indicator or output0
// - output1 select: bus activity or output1
// - set level drives pin low
// - reset value is 0x0015
// - low six bits read identifier 010101
module self_control_power_led
  import self_control_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic io_write_in_range,
  input wire logic sleep_pin,
  input wire logic link_indicator_n,
  input wire logic bus_activity_indicator_n,
  output logic chip_reset,
  output logic partial_reset,
  output logic frame_enable,
  output logic [1:0] power_mode,
  output logic general_output0_n,
  output logic general_output1_n
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] ctrl_q, ctrl_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic chip_reset_q, chip_reset_d;
  logic partial_q, partial_d;
  logic [1:0] power_q, power_d;
  logic do_write;
  logic wake;
  power_state_t pstate;

  // merge byte lanes of a 16-bit register with the writable mask
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] m;
    m = {{8{strb[1]}}, {8{strb[0]}}} & WRITABLE_MASK;
    merge16 = (old & ~m) | (data[15:0] & m);
  endfunction

  // register read view: identifier always overlays the low bits
  function automatic logic [15:0] ctrl_view(input logic [15:0] r);
    ctrl_view = {r[15:6], SELF_CONTROL_ID};
  endfunction

  // ----------------------------------------------------------------
  // axi write path
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  // host io write or bus write to the wake address leaves suspend
  assign wake = io_write_in_range ||
                (do_write && awaddr_q == IO_WRITE_ADDR);

  // address and data may arrive in either order; response after both
  always_comb
  begin
    awaddr_d = awaddr_q;
    aw_held_d = aw_held_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    w_held_d = w_held_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    ctrl_d = ctrl_q;
    chip_reset_d = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      awaddr_d = s_axi_awaddr;
      aw_held_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
      w_held_d = 1'b1;
    end
    if (do_write)
    begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      if (awaddr_q == SELF_CONTROL_ADDR)
      begin
        ctrl_d = merge16(ctrl_q, wdata_q, wstrb_q);
        if (wstrb_q[0] && wdata_q[RESET_BIT])
        begin
          // act-once: the chip reset it causes also clears the register
          chip_reset_d = 1'b1;
          ctrl_d = SELF_CONTROL_RESET;
        end
      end
      else if (awaddr_q != IO_WRITE_ADDR)
        bresp_d = RESP_SLVERR;
    end
    else if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
    // wake clears suspend; a self-control register write in the same cycle wins
    if (wake && !(do_write && awaddr_q == SELF_CONTROL_ADDR))
      ctrl_d[SUSPEND_BIT] = 1'b0;
  end

  // ----------------------------------------------------------------
  // axi read path
  // ----------------------------------------------------------------
  assign s_axi_arready = !rvalid_q;
  always_comb
  begin
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      case (s_axi_araddr)
        SELF_CONTROL_ADDR: rdata_d = {16'h0000, ctrl_view(ctrl_q)};
        IO_WRITE_ADDR: rdata_d = 32'h00000000;
        POWER_STATUS_ADDR: rdata_d = {30'h00000000, power_q};
        default:
        begin
          rdata_d = 32'h00000000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
  end

  // ----------------------------------------------------------------
  // power mode and resets
  // ----------------------------------------------------------------
  power_mode_ctrl u_power
  (
    .suspend_set(ctrl_q[SUSPEND_BIT]),
    .sleep_enable(ctrl_q[SLEEP_EN_BIT]),
    .standby_select(ctrl_q[STANDBY_BIT]),
    .sleep_pin(sleep_pin),
    .power_state(pstate)
  );
  // partial reset held through software suspend only; base and this register survive
  always_comb
  begin
    power_d = pstate;
    partial_d = (pstate == PWR_SW_SUSPEND);
  end
  // frames only move when fully active
  assign frame_enable = (power_q == PWR_ACTIVE) && !chip_reset_q;
  assign chip_reset = chip_reset_q;
  assign partial_reset = partial_q;
  assign power_mode = power_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ctrl_q <= SELF_CONTROL_RESET;
      awaddr_q <= 8'h00;
      aw_held_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h00000000;
      chip_reset_q <= 1'b0;
      partial_q <= 1'b0;
      power_q <= PWR_ACTIVE;
    end
    else if (clk_en)
    begin
      ctrl_q <= ctrl_d;
      awaddr_q <= awaddr_d;
      aw_held_q <= aw_held_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      w_held_q <= w_held_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      chip_reset_q <= chip_reset_d;
      partial_q <= partial_d;
      power_q <= power_d;
    end
  end

  // ----------------------------------------------------------------
  // shared pins
  // ----------------------------------------------------------------
  pin_select u_pin0
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .select(ctrl_q[OUT0_SEL_BIT]),
    .level(ctrl_q[OUT0_LVL_BIT]),
    .indicator_n(link_indicator_n),
    .pin_n(general_output0_n)
  );
  pin_select u_pin1
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .select(ctrl_q[OUT1_SEL_BIT]),
    .level(ctrl_q[OUT1_LVL_BIT]),
    .indicator_n(bus_activity_indicator_n),
    .pin_n(general_output1_n)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reset_self_clear: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && chip_reset_q) |-> ctrl_q[RESET_BIT] == 1'b0)
    else $error("reset bit not cleared");
  a_id_bits_fixed: assert property (@(posedge clock) disable iff (sys_rst)
    (rvalid_q && $rose(rvalid_q) && $past(s_axi_araddr) == SELF_CONTROL_ADDR)
      |-> rdata_q[5:0] == SELF_CONTROL_ID)
    else $error("identifier bits wrong");
  a_suspend_partial: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && ctrl_q[SUSPEND_BIT]) |=> partial_q)
    else $error("partial reset missing in suspend");
  a_no_frames_susp: assert property (@(posedge clock) disable iff (sys_rst)
    partial_q |-> !frame_enable)
    else $error("frames enabled in suspend");
  a_wake_clears: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && io_write_in_range && !do_write) |=> !ctrl_q[SUSPEND_BIT])
    else $error("wake did not clear suspend");
  a_sleep_ignored: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && !ctrl_q[SLEEP_EN_BIT] && !ctrl_q[SUSPEND_BIT]) |=> power_q == PWR_ACTIVE)
    else $error("sleep pin not ignored");
  a_sleep_awake: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && ctrl_q[SLEEP_EN_BIT] && sleep_pin && !ctrl_q[SUSPEND_BIT])
      |=> power_q == PWR_ACTIVE)
    else $error("high sleep pin did not keep device active");
  a_sleep_mode: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && ctrl_q[SLEEP_EN_BIT] && !sleep_pin && !ctrl_q[SUSPEND_BIT])
      |=> power_q == (($past(ctrl_q[STANDBY_BIT])) ? PWR_HW_STANDBY : PWR_HW_SUSPEND))
    else $error("wrong hardware sleep mode");
  a_out0_level: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && ctrl_q[OUT0_SEL_BIT]) |=> general_output0_n == !$past(ctrl_q[OUT0_LVL_BIT]))
    else $error("output0 level wrong");
  a_out1_indicator: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && !ctrl_q[OUT1_SEL_BIT])
      |=> general_output1_n == $past(bus_activity_indicator_n))
    else $error("output1 indicator wrong");
endmodule // self_control_power_led
`default_nettype wire

// ===== tb/host_bus_model.sv
/*
  Host side model: an AXI4-Lite master for the self-control registers and
  the in-range I/O write strobe that wakes the device.
  Assumes readies come from registers only, so they are stable between edges.
*/
`default_nettype none
module host_bus_model
(
  input wire logic clock,
  output var logic [7:0] s_axi_awaddr,
  output var logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output var logic [31:0] s_axi_wdata,
  output var logic [3:0] s_axi_wstrb,
  output var logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output var logic s_axi_bready,
  output var logic [7:0] s_axi_araddr,
  output var logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output var logic s_axi_rready,
  output var logic io_write_in_range
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // idle levels
  // ------------------------------------------------------------------
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    io_write_in_range = 1'b0;
  end
  // ready sampled mid-cycle; the handshake lands at the next rising edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw, w, ta, tw, t;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    aw = 0;
    w = 0;
    while (!(aw && w))
    begin
      @(negedge clock);
      ta = !aw && (s_axi_awready === 1'b1);
      tw = !w && (s_axi_wready === 1'b1);
      @(posedge clock);
      if (ta) begin aw = 1; s_axi_awvalid <= 1'b0; end
      if (tw) begin w = 1; s_axi_wvalid <= 1'b0; end
    end
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge clock);
      t = (s_axi_bvalid === 1'b1);
      r = s_axi_bresp;
      @(posedge clock);
    end while (!t);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit t;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(negedge clock);
      t = (s_axi_arready === 1'b1);
      @(posedge clock);
    end while (!t);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge clock);
      t = (s_axi_rvalid === 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
    end while (!t);
    s_axi_rready <= 1'b0;
  endtask
  // one-cycle strobe: an I/O write that hit the device's space
  task automatic wake();
    @(posedge clock);
    io_write_in_range <= 1'b1;
    @(posedge clock);
    io_write_in_range <= 1'b0;
  endtask
endmodule // host_bus_model
`default_nettype wire

// ===== tb/self_control_power_led_tb.sv
/*
  Self-checking bench for the self-control block: register access,
  chip reset, suspend and wake, sleep pin modes, shared pins.
  Assumes the host model above drives the AXI4-Lite port.
*/
`default_nettype none
module self_control_power_led_tb
  import self_control_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, sys_rst, clk_en, sleep_pin, link_n, bus_n, io_wr;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, power_mode;
  logic chip_reset, partial_reset, frame_enable, out0_n, out1_n;
  int fail_count = 0;
  int tests_run = 0;
  int pulses = 0;
  logic [15:0] sd [5] = '{16'h0200, 16'h0600, 16'h0600, 16'h0400, 16'h0300};
  logic sp [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [1:0] sm [5] = '{PWR_HW_SUSPEND, PWR_HW_STANDBY, PWR_ACTIVE, PWR_ACTIVE, PWR_SW_SUSPEND};
  self_control_power_led u_self_control_power_led (.clock(clock), .sys_rst(sys_rst),
    .clk_en(clk_en), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .io_write_in_range(io_wr),
    .sleep_pin(sleep_pin), .link_indicator_n(link_n), .bus_activity_indicator_n(bus_n),
    .chip_reset(chip_reset), .partial_reset(partial_reset), .frame_enable(frame_enable),
    .power_mode(power_mode), .general_output0_n(out0_n), .general_output1_n(out1_n));
  host_bus_model u_host_bus_model (.clock(clock), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .io_write_in_range(io_wr));
  // ------------------------------------------------------------------
  // clock, pulse counter, helpers
  // ------------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // counts chip reset pulses so width is checked, not only presence
  always @(posedge clock)
  begin
    if (chip_reset === 1'b1) pulses <= pulses + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    u_host_bus_model.axi_write(a, d, r);
    check(r, RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [1:0] r;
    logic [31:0] d;
    u_host_bus_model.axi_read(a, d, r);
    check(d, exp);
    check(r, er);
  endtask
  // mode and pins follow one cycle after the register; wait three rising edges, then sample mid-cycle
  task automatic settle();
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic stop_test();
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    fail_count++;
    stop_test();
  end
  // ------------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------------
  initial
  begin
    int n;
    logic [1:0] r;
    {sys_rst, clk_en, sleep_pin, link_n, bus_n} = 5'b11111;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    rd(SELF_CONTROL_ADDR, 32'h0000_0015, RESP_OKAY);
    rd(8'h0C, 32'h0000_0000, RESP_SLVERR);
    wr(SELF_CONTROL_ADDR, 32'h0000_302A);
    settle();
    check({out0_n, out1_n}, 2'h3);
    rd(SELF_CONTROL_ADDR, 32'h0000_3015, RESP_OKAY);
    wr(SELF_CONTROL_ADDR, 32'h0000_F000);
    settle();
    check({out0_n, out1_n}, 2'h0);
    wr(SELF_CONTROL_ADDR, 32'h0000_C000);
    link_n <= 1'b0;
    settle();
    check({out0_n, out1_n}, 2'h1);
    @(posedge clock);
    link_n <= 1'b1;
    bus_n <= 1'b0;
    settle();
    check({out0_n, out1_n}, 2'h2);
    n = pulses;
    wr(SELF_CONTROL_ADDR, 32'h0000_3040);
    settle();
    check(pulses, n + 1);
    rd(SELF_CONTROL_ADDR, 32'h0000_0015, RESP_OKAY);
    wr(SELF_CONTROL_ADDR, 32'h0000_3100);
    settle();
    check({partial_reset, frame_enable, power_mode}, {2'b10, PWR_SW_SUSPEND});
    rd(SELF_CONTROL_ADDR, 32'h0000_3115, RESP_OKAY);
    rd(POWER_STATUS_ADDR, 32'(PWR_SW_SUSPEND), RESP_OKAY);
    u_host_bus_model.wake();
    settle();
    check({frame_enable, power_mode}, {1'b1, PWR_ACTIVE});
    for (int i = 0; i < 5; i++)
    begin
      wr(SELF_CONTROL_ADDR, {16'h0, sd[i]});
      sleep_pin <= sp[i];
      settle();
      check(power_mode, sm[i]);
    end
    // a bus write to the wake word leaves software suspend as well
    wr(IO_WRITE_ADDR, 32'h0000_0000);
    settle();
    check(power_mode, PWR_ACTIVE);
    rd(SELF_CONTROL_ADDR, 32'h0000_0215, RESP_OKAY);
    rd(IO_WRITE_ADDR, 32'h0000_0000, RESP_OKAY);
    // an unmapped write is refused and leaves the register alone
    u_host_bus_model.axi_write(8'h0C, 32'h0000_FFFF, r);
    check(r, RESP_SLVERR);
    rd(SELF_CONTROL_ADDR, 32'h0000_0215, RESP_OKAY);
    // clock enable low freezes the mode although the pin asks for sleep
    clk_en <= 1'b0;
    sleep_pin <= 1'b0;
    settle();
    check(power_mode, PWR_ACTIVE);
    @(posedge clock);
    clk_en <= 1'b1;
    settle();
    check(power_mode, PWR_HW_SUSPEND);
    // reset in mid-run brings the register and mode back from sleep
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rd(SELF_CONTROL_ADDR, 32'h0000_0015, RESP_OKAY);
    check({partial_reset, frame_enable, power_mode}, {2'b01, PWR_ACTIVE});
    stop_test();
  end
endmodule // self_control_power_led_tb
`default_nettype wire
